// File: include/gphs_pkg.sv
package gphs_pkg;

    // ========================================
    // Command word values
    localparam logic [15:0] CMD_NONE        = 16'h0000;
    localparam logic [15:0] CMD_APPLY       = 16'h0001;
    localparam logic [15:0] CMD_STORE       = 16'h0002;
    localparam logic [15:0] CMD_CLR_DIR     = 16'h0004;
    localparam logic [15:0] CMD_CAPTURE     = 16'h0008;
    localparam logic [15:0] CMD_GO_OUTER    = 16'h0100;
    localparam logic [15:0] CMD_GO_INNER    = 16'h0200;
    localparam logic [15:0] CMD_CREEP_INNER = 16'h0400;
    localparam logic [15:0] CMD_CREEP_OUTER = 16'h0800;

    // ========================================
    // State word bits and diagnostic codes
    localparam int          ST_ALIVE_BIT     = 6;
    localparam int          ST_ACK_BIT       = 12;
    localparam logic [15:0] ST_RESET         = 16'h0040;
    localparam logic [15:0] DIAG_NONE        = 16'h0000;
    localparam logic [15:0] DIAG_MOTOR_OFF   = 16'h0001;
    localparam logic [15:0] DIAG_TORQUE_OPEN = 16'h0002;
    localparam logic [15:0] DIAG_FATAL       = 16'h0100;

    // ========================================
    // Profiles and recipes
    localparam logic [7:0] PROFILE_MOTOR_ON  = 8'h03;
    localparam logic [7:0] PROFILE_MOTOR_OFF = 8'h05;
    localparam int         RECIPE_COUNT      = 32;
    localparam logic [7:0] RECIPE_MAX        = 8'h20;
    localparam int         RECIPE_AW         = 5;

    // ========================================
    // Timing
    localparam int CLK_HZ           = 20000000;
    localparam int LINK_CYCLE_MS    = 10;
    localparam int LINK_CYCLE_CLKS  = LINK_CYCLE_MS * (CLK_HZ / 1000);
    localparam int STO_DISCREP_US   = 100;
    localparam int STO_DISCREP_CLKS = STO_DISCREP_US * (CLK_HZ / 1000000);

    // ========================================
    // Types
    typedef struct packed {
        logic [7:0]  profile_selection;
        logic [7:0]  position_window;
        logic [7:0]  clamp_force_level;
        logic [7:0]  travel_speed_percent;
        logic [15:0] outer_target_pos;
        logic [15:0] switchover_pos;
        logic [15:0] learned_part_pos;
        logic [15:0] inner_target_pos;
    } gphs_param_set_type;

    localparam gphs_param_set_type PARAM_RESET = '0;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_FETCH = 2'b01,
        HS_ACK   = 2'b10
    } gphs_hs_state_type;

    typedef enum logic [1:0] {
        MOT_STOP  = 2'b00,
        MOT_OUTER = 2'b01,
        MOT_INNER = 2'b10
    } gphs_motion_type;

endpackage : gphs_pkg

// File: include/gphs_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gphs_mem_if;
    import gphs_pkg::*;
    logic                     wr_en;
    logic [RECIPE_AW-1:0]     wr_addr;
    gphs_param_set_type       wr_data;
    logic [RECIPE_AW-1:0]     rd_addr;
    gphs_param_set_type       rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : gphs_mem_if
`default_nettype wire

// File: rtl/gphs_recipe_mem.sv
`timescale 1ns/100ps
`default_nettype none
module gphs_recipe_mem #(
    parameter int DEPTH = gphs_pkg::RECIPE_COUNT
) (
    input  wire logic clk,
    gphs_mem_if.mem   port
);
    import gphs_pkg::*;

    // ========================================
    // Recipe storage, registered read
    gphs_param_set_type store_reg [DEPTH];
    gphs_param_set_type rd_reg;

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            store_reg[port.wr_addr] <= port.wr_data;
        end
        rd_reg <= store_reg[port.rd_addr];
    end

    assign port.rd_data = rd_reg;

endmodule : gphs_recipe_mem
`default_nettype wire

// File: rtl/gphs_top.sv
`timescale 1ns/100ps
`default_nettype none
module gphs_top #(
    parameter int CYCLE_CLKS = gphs_pkg::LINK_CYCLE_CLKS,
    parameter int DISCREP_CLKS = gphs_pkg::STO_DISCREP_CLKS
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [15:0]             command_word,
    input  wire logic [7:0]              profile_selection,
    input  wire logic [7:0]              recipe_index,
    input  wire logic [7:0]              position_window,
    input  wire logic [7:0]              clamp_force_level,
    input  wire logic [7:0]              travel_speed_percent,
    input  wire logic [15:0]             outer_target_pos,
    input  wire logic [15:0]             switchover_pos,
    input  wire logic [15:0]             learned_part_pos,
    input  wire logic [15:0]             inner_target_pos,
    input  wire logic [15:0]             jaw_pos_in,
    input  wire logic                    torque_off_line_a,
    input  wire logic                    torque_off_line_b,
    output logic [15:0]                  state_word,
    output logic [15:0]                  diag_code,
    output logic [15:0]                  measured_jaw_pos,
    output gphs_pkg::gphs_param_set_type active_params,
    output logic                         torque_enable,
    output logic                         travel_outer,
    output logic                         travel_inner,
    output logic                         creep_inner,
    output logic                         creep_outer,
    output logic                         clear_direction_latch,
    output logic                         link_cycle_tick
);
    import gphs_pkg::*;

    localparam int CW = $clog2(CYCLE_CLKS + 1);
    localparam int DW = $clog2(DISCREP_CLKS + 1);

    // ========================================
    // Command decoding
    function automatic logic cmd_valid(input logic [15:0] cmd);
        unique case (cmd)
            CMD_NONE, CMD_APPLY, CMD_STORE, CMD_CLR_DIR, CMD_CAPTURE,
            CMD_GO_OUTER, CMD_GO_INNER, CMD_CREEP_INNER,
            CMD_CREEP_OUTER: cmd_valid = 1'b1;
            default:         cmd_valid = 1'b0;
        endcase
    endfunction : cmd_valid

    function automatic logic idx_in_store(input logic [7:0] idx);
        idx_in_store = (idx != 8'h00) && (idx <= RECIPE_MAX);
    endfunction : idx_in_store

    gphs_mem_if mem_bus ();

    gphs_recipe_mem #(
        .DEPTH (RECIPE_COUNT)
    ) u_mem (
        .clk  (clk),
        .port (mem_bus.mem)
    );

    // ========================================
    // Link cycle timer
    logic [CW-1:0] cyc_reg;
    logic [CW-1:0] cyc_next;
    logic          tick;

    assign tick = (cyc_reg == CW'(CYCLE_CLKS - 1));

    always_comb begin
        cyc_next = tick ? '0 : cyc_reg + CW'(1);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cyc_reg <= '0;
        end else begin
            cyc_reg <= cyc_next;
        end
    end

    // ========================================
    // Torque-off supervision
    logic [DW-1:0] disc_reg;
    logic [DW-1:0] disc_next;
    logic          fatal_reg;
    logic          fatal_next;
    logic          lines_high;
    logic          mismatch;

    assign mismatch   = torque_off_line_a ^ torque_off_line_b;
    assign lines_high = torque_off_line_a & torque_off_line_b;

    always_comb begin
        disc_next  = mismatch ? disc_reg + DW'(1) : '0;
        fatal_next = fatal_reg;
        if (mismatch && disc_reg == DW'(DISCREP_CLKS - 1)) begin
            disc_next  = disc_reg;
            fatal_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            disc_reg  <= '0;
            fatal_reg <= 1'b0;
        end else begin
            disc_reg  <= disc_next;
            fatal_reg <= fatal_next;
        end
    end

    // ========================================
    // Handshake, parameter adoption, recipe store
    gphs_hs_state_type  hs_reg;
    gphs_hs_state_type  hs_next;
    gphs_param_set_type act_reg;
    gphs_param_set_type act_next;
    gphs_param_set_type cyclic;
    logic               adopt;
    logic               cmd_ok;

    assign cyclic = '{profile_selection, position_window,
                      clamp_force_level, travel_speed_percent,
                      outer_target_pos, switchover_pos,
                      learned_part_pos, inner_target_pos};
    assign cmd_ok = tick && cmd_valid(command_word) && !fatal_reg;

    always_comb begin
        hs_next          = hs_reg;
        act_next         = act_reg;
        adopt            = 1'b0;
        mem_bus.wr_en    = 1'b0;
        mem_bus.wr_data  = cyclic;
        mem_bus.wr_addr  = RECIPE_AW'(recipe_index - 8'h01);
        mem_bus.rd_addr  = RECIPE_AW'(recipe_index - 8'h01);
        unique case (hs_reg)
            HS_IDLE: begin
                if (cmd_ok && command_word == CMD_APPLY) begin
                    if (recipe_index == 8'h00) begin
                        act_next = cyclic;
                        adopt    = 1'b1;
                        hs_next  = HS_ACK;
                    end else if (idx_in_store(recipe_index)) begin
                        hs_next  = HS_FETCH;
                    end
                end
                if (cmd_ok && idx_in_store(recipe_index)) begin
                    if (command_word == CMD_STORE) begin
                        mem_bus.wr_en = 1'b1;
                    end
                    if (command_word == CMD_CAPTURE) begin
                        mem_bus.wr_en = 1'b1;
                        mem_bus.wr_data.learned_part_pos = jaw_pos_in;
                    end
                end
            end
            HS_FETCH: begin
                act_next = mem_bus.rd_data;
                adopt    = 1'b1;
                hs_next  = HS_ACK;
            end
            HS_ACK: begin
                if (tick && command_word == CMD_NONE) begin
                    hs_next = HS_IDLE;
                end
            end
            default: begin
                hs_next = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hs_reg  <= HS_IDLE;
            act_reg <= PARAM_RESET;
        end else begin
            hs_reg  <= hs_next;
            act_reg <= act_next;
        end
    end

    // ========================================
    // Motor enable and motion
    logic            motor_reg;
    logic            motor_next;
    gphs_motion_type mot_reg;
    gphs_motion_type mot_next;
    logic [1:0]      creep_reg;
    logic [1:0]      creep_next;
    logic            clr_reg;
    logic            clr_next;
    logic            run_ok;

    assign run_ok = motor_reg && lines_high && !fatal_reg;

    always_comb begin
        motor_next = motor_reg;
        if (adopt && act_next.profile_selection == PROFILE_MOTOR_ON) begin
            motor_next = 1'b1;
        end
        if (adopt && act_next.profile_selection == PROFILE_MOTOR_OFF) begin
            motor_next = 1'b0;
        end
        if (!lines_high || fatal_reg) begin
            motor_next = 1'b0;
        end
    end

    always_comb begin
        mot_next   = mot_reg;
        creep_next = creep_reg;
        clr_next   = cmd_ok && command_word == CMD_CLR_DIR;
        if (cmd_ok) begin
            creep_next = {command_word == CMD_CREEP_OUTER,
                          command_word == CMD_CREEP_INNER};
            if (command_word == CMD_GO_OUTER) begin
                mot_next = MOT_OUTER;
            end else if (command_word == CMD_GO_INNER) begin
                mot_next = MOT_INNER;
            end else if (command_word == CMD_CREEP_INNER ||
                         command_word == CMD_CREEP_OUTER) begin
                mot_next = MOT_STOP;
            end
        end
        if (!run_ok) begin
            mot_next   = MOT_STOP;
            creep_next = 2'b00;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            motor_reg <= 1'b0;
            mot_reg   <= MOT_STOP;
            creep_reg <= 2'b00;
            clr_reg   <= 1'b0;
        end else begin
            motor_reg <= motor_next;
            mot_reg   <= mot_next;
            creep_reg <= creep_next;
            clr_reg   <= clr_next;
        end
    end

    // ========================================
    // Input image
    logic [15:0] st_reg;
    logic [15:0] st_next;
    logic [15:0] diag_reg;
    logic [15:0] diag_next;
    logic [15:0] pos_reg;
    logic [15:0] pos_next;

    always_comb begin
        st_next               = ST_RESET;
        st_next[ST_ALIVE_BIT] = 1'b1;
        st_next[ST_ACK_BIT]   = (hs_next == HS_ACK);
        pos_next              = jaw_pos_in;
        if (fatal_next) begin
            diag_next = DIAG_FATAL;
        end else if (!lines_high) begin
            diag_next = DIAG_TORQUE_OPEN;
        end else if (!motor_next) begin
            diag_next = DIAG_MOTOR_OFF;
        end else begin
            diag_next = DIAG_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg   <= ST_RESET;
            diag_reg <= DIAG_MOTOR_OFF;
            pos_reg  <= 16'h0000;
        end else begin
            st_reg   <= st_next;
            diag_reg <= diag_next;
            pos_reg  <= pos_next;
        end
    end

    // ========================================
    // Outputs
    assign state_word            = st_reg;
    assign diag_code             = diag_reg;
    assign measured_jaw_pos      = pos_reg;
    assign active_params         = act_reg;
    assign torque_enable         = run_ok;
    assign travel_outer          = (mot_reg == MOT_OUTER);
    assign travel_inner          = (mot_reg == MOT_INNER);
    assign creep_inner           = creep_reg[0];
    assign creep_outer           = creep_reg[1];
    assign clear_direction_latch = clr_reg;
    assign link_cycle_tick       = tick;

endmodule : gphs_top
`default_nettype wire

// File: sim/gphs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Handshake and torque-off checker
module gphs_monitor #(
    parameter int CYCLE_CLKS   = 8,
    parameter int DISCREP_CLKS = 4
) (
    input wire logic                         clk,
    input wire logic                         resetn,
    input wire logic [15:0]                  command_word,
    input wire logic [7:0]                   recipe_index,
    input wire logic                         torque_off_line_a,
    input wire logic                         torque_off_line_b,
    input wire logic [15:0]                  state_word,
    input wire logic [15:0]                  diag_code,
    input wire gphs_pkg::gphs_param_set_type active_params,
    input wire logic                         torque_enable,
    input wire logic                         travel_outer,
    input wire logic                         travel_inner,
    input wire logic                         creep_inner,
    input wire logic                         link_cycle_tick
);
    import gphs_pkg::*;
    int   gap_reg, gap_next, mis_reg, mis_next;
    logic seen_reg, seen_next, tk, la, lb, bad;
    assign tk  = link_cycle_tick;
    assign la  = torque_off_line_a;
    assign lb  = torque_off_line_b;
    assign bad = !$onehot(command_word) || (command_word & 16'hF0F0) != 0;
    always_comb begin
        gap_next  = tk ? 0 : gap_reg + 1;
        seen_next = seen_reg | tk;
        mis_next  = (la != lb) ? mis_reg + 1 : 0;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gap_reg  <= 0;
            seen_reg <= 1'h0;
            mis_reg  <= 0;
        end else begin
            gap_reg  <= gap_next;
            seen_reg <= seen_next;
            mis_reg  <= mis_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    alive_flag_a:
        assert property (state_word[ST_ALIVE_BIT]) else $error("alive low");
    ack_raise_a:
        assert property (tk && command_word == CMD_APPLY && !recipe_index
            && !state_word[ST_ACK_BIT] && diag_code != DIAG_FATAL
            |=> state_word[ST_ACK_BIT]) else $error("ack not set");
    ack_drop_a:
        assert property (tk && command_word == CMD_NONE
            |=> !state_word[ST_ACK_BIT]) else $error("ack not cleared");
    ack_hold_a:
        assert property (state_word[ST_ACK_BIT] && !(tk && !command_word)
            |=> state_word[ST_ACK_BIT]) else $error("ack dropped early");
    param_gate_a:
        assert property (!$stable(active_params)
            |-> $rose(state_word[ST_ACK_BIT])) else $error("params leaked");
    bad_cmd_a:
        assert property (tk && command_word != 0 && bad
            |=> $stable(state_word) && $stable(active_params))
        else $error("invalid command acted on");
    fatal_set_a:
        assert property (mis_reg == DISCREP_CLKS
            |-> ##[0:2] diag_code == DIAG_FATAL && !torque_enable)
        else $error("mismatch not fatal");
    fatal_keep_a:
        assert property (diag_code == DIAG_FATAL |=> diag_code == DIAG_FATAL
            && !torque_enable && !travel_outer && !travel_inner)
        else $error("fatal left");
    safe_low_a:
        assert property ((!la && !lb)[*2]
            |-> !torque_enable && !travel_outer && !travel_inner)
        else $error("torque with lines low");
    motor_off_a:
        assert property ((la && lb)[*3] ##0 !torque_enable
            && diag_code != DIAG_FATAL |-> diag_code == DIAG_MOTOR_OFF)
        else $error("motor off code missing");
    go_outer_a:
        assert property (tk && command_word == CMD_GO_OUTER && torque_enable
            |=> travel_outer && !travel_inner) else $error("no outer travel");
    creep_stop_a:
        assert property (creep_inner && tk && command_word != CMD_CREEP_INNER
            |=> !creep_inner) else $error("creep kept");
    tick_gap_a:
        assert property (tk && seen_reg |-> gap_reg == CYCLE_CLKS - 1)
        else $error("link tick spacing");
endmodule : gphs_monitor
bind gphs_top gphs_monitor #(
    .CYCLE_CLKS(CYCLE_CLKS),
    .DISCREP_CLKS(DISCREP_CLKS)
) mon (
    .clk(clk), .resetn(resetn), .command_word(command_word),
    .recipe_index(recipe_index), .torque_off_line_a(torque_off_line_a),
    .torque_off_line_b(torque_off_line_b), .state_word(state_word),
    .diag_code(diag_code), .active_params(active_params),
    .torque_enable(torque_enable), .travel_outer(travel_outer),
    .travel_inner(travel_inner), .creep_inner(creep_inner),
    .link_cycle_tick(link_cycle_tick)
);
`default_nettype wire

// File: sim/gphs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Host master: one command per request
module gphs_host_model (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         link_cycle_tick,
    input  wire logic [15:0]                  state_word,
    input  wire logic                         start,
    input  wire logic                         handshake,
    input  wire logic [15:0]                  cmd_in,
    input  wire logic [7:0]                   idx_in,
    input  wire gphs_pkg::gphs_param_set_type img_in,
    output logic                              busy,
    output logic [15:0]                       command_word,
    output logic [7:0]                        recipe_index,
    output gphs_pkg::gphs_param_set_type      image
);
    import gphs_pkg::*;
    int                 phase = 0;
    logic               hs_r  = 1'h0;
    logic               step;
    logic [15:0]        cmd_r = 16'h0000;
    logic [15:0]        cw_q  = 16'h0000;
    logic [7:0]         idx_r = 8'h00;
    logic [7:0]         idx_q = 8'h00;
    gphs_param_set_type img_r = PARAM_RESET;
    gphs_param_set_type img_q = PARAM_RESET;
    assign busy         = (phase != 0);
    assign command_word = cw_q;
    assign recipe_index = idx_q;
    assign image        = img_q;
    assign step = hs_r ? (state_word[ST_ACK_BIT] ^ (phase == 2))
                       : link_cycle_tick;
    always @(posedge clk) begin
        if (!resetn)
            phase <= 0;
        else if (phase == 0 && start) begin
            phase <= 1;
            hs_r  <= handshake;
            cmd_r <= cmd_in;
            idx_r <= idx_in;
            img_r <= img_in;
        end else if (phase != 0 && step)
            phase <= (phase + 1) % 3;
    end
    always @(negedge clk) begin
        cw_q  <= (phase == 1) ? cmd_r : CMD_NONE;
        idx_q <= idx_r;
        img_q <= img_r;
    end
endmodule : gphs_host_model
`default_nettype wire

// File: sim/gripper_process_data_handshake_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ========
// Testbench
module gripper_process_data_handshake_tb_top;
    import gphs_pkg::*;
    logic               clk    = 1'h0;
    logic               resetn = 1'h0;
    logic               line_a = 1'h1;
    logic               line_b = 1'h1;
    logic               start  = 1'h0;
    logic               hs     = 1'h0;
    logic [15:0]        cmd    = 16'h0000;
    logic [7:0]         idx    = 8'h00;
    logic [15:0]        jaw    = 16'h0000;
    logic [5:0]         seen_o = 6'h00;
    logic [7:0]         cdl_n  = 8'h00;
    gphs_param_set_type img    = PARAM_RESET;
    gphs_param_set_type im, ap;
    logic [15:0]        cw, sw, dg, mp;
    logic [7:0]         ri;
    logic               busy, ten, t_o, t_i, c_i, c_o, cdl, tick;
    int                 bad_count       = 0;
    int                 samples_checked = 0;
    gphs_host_model host_m (.clk(clk), .resetn(resetn), .link_cycle_tick(tick),
        .state_word(sw), .start(start), .handshake(hs), .cmd_in(cmd),
        .idx_in(idx), .img_in(img), .busy(busy), .command_word(cw),
        .recipe_index(ri), .image(im));
    gphs_top #(.CYCLE_CLKS(8), .DISCREP_CLKS(4)) dut (.clk(clk),
        .resetn(resetn), .command_word(cw), .recipe_index(ri),
        .profile_selection(im.profile_selection),
        .position_window(im.position_window),
        .clamp_force_level(im.clamp_force_level),
        .travel_speed_percent(im.travel_speed_percent),
        .outer_target_pos(im.outer_target_pos),
        .switchover_pos(im.switchover_pos),
        .learned_part_pos(im.learned_part_pos),
        .inner_target_pos(im.inner_target_pos), .jaw_pos_in(jaw),
        .torque_off_line_a(line_a), .torque_off_line_b(line_b),
        .state_word(sw), .diag_code(dg), .measured_jaw_pos(mp),
        .active_params(ap), .torque_enable(ten), .travel_outer(t_o),
        .travel_inner(t_i), .creep_inner(c_i), .creep_outer(c_o),
        .clear_direction_latch(cdl), .link_cycle_tick(tick));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        seen_o <= start ? 6'h00
                        : seen_o | {sw[ST_ACK_BIT], c_o, c_i, t_i, t_o, cdl};
        if (cdl === 1'h1)
            cdl_n <= cdl_n + 8'h01;
    end
    task automatic check(input string what, input logic [95:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic host(input logic h, input logic [15:0] c,
                        input logic [7:0] i);
        int n;
        hs     = h;
        cmd    = c;
        idx    = i;
        start  = 1'h1;
        @(negedge clk);
        start = 1'h0;
        n = 0;
        while (busy !== 1'h0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : host
    task automatic t_reset();
        check("state", sw, 16'h0040);
        check("diag", dg, DIAG_MOTOR_OFF);
        check("params", ap, PARAM_RESET);
        check("torque", ten, 1'h0);
    endtask : t_reset
    task automatic t_apply();
        img = '{8'h03, 8'h0A, 8'h32, 8'h4B,
                16'h0100, 16'h0200, 16'h0300, 16'h0400};
        jaw = 16'h0ABC;
        host(1'h1, CMD_APPLY, 8'h00);
        check("params", ap, img);
        check("ack", seen_o[5], 1'h1);
        check("state", sw, 16'h0040);
        check("torque", ten, 1'h1);
        check("pos", mp, 16'h0ABC);
        img.clamp_force_level = 8'h10;
        host(1'h0, CMD_NONE, 8'h00);
        check("held", ap.clamp_force_level, 8'h32);
    endtask : t_apply
    task automatic t_motion();
        logic [15:0] c [5] = '{CMD_CLR_DIR, CMD_GO_OUTER, CMD_GO_INNER,
                               CMD_CREEP_INNER, CMD_CREEP_OUTER};
        for (int k = 0; k < 5; k++) begin
            host(1'h0, c[k], 8'h00);
            check("seen", seen_o[k], 1'h1);
            check("creep", {c_o, c_i}, 2'h0);
        end
        check("pulse", cdl_n, 8'h01);
        check("travel", {t_i, t_o}, 2'h0);
    endtask : t_motion
    task automatic t_invalid();
        logic [15:0] c [4] = '{16'h0003, 16'h1000, 16'h0010, 16'h8001};
        for (int k = 0; k < 4; k++) begin
            host(1'h0, c[k], 8'h00);
            check("ignored", seen_o, 6'h00);
            check("force", ap.clamp_force_level, 8'h32);
        end
    endtask : t_invalid
    task automatic t_recipe();
        gphs_param_set_type a;
        img.clamp_force_level = 8'h21;
        a = img;
        host(1'h0, CMD_STORE, 8'h20);
        jaw = 16'h1234;
        img.clamp_force_level = 8'h44;
        host(1'h0, CMD_CAPTURE, 8'h01);
        host(1'h1, CMD_APPLY, 8'h20);
        check("recipe", ap, a);
        a = img;
        a.learned_part_pos = 16'h1234;
        host(1'h1, CMD_APPLY, 8'h01);
        check("capture", ap, a);
        host(1'h0, CMD_APPLY, 8'h21);
        check("range", seen_o[5], 1'h0);
    endtask : t_recipe
    task automatic t_torque();
        host(1'h0, CMD_GO_OUTER, 8'h00);
        check("go", t_o, 1'h1);
        line_a = 1'h0;
        line_b = 1'h0;
        repeat (3) @(negedge clk);
        check("off", {ten, t_o, t_i}, 3'h0);
        check("diag", dg, DIAG_TORQUE_OPEN);
        line_a = 1'h1;
        line_b = 1'h1;
        repeat (3) @(negedge clk);
        check("diag", dg, DIAG_MOTOR_OFF);
        host(1'h1, CMD_APPLY, 8'h00);
        host(1'h0, CMD_GO_OUTER, 8'h00);
        check("go", t_o, 1'h1);
        line_b = 1'h0;
        repeat (8) @(negedge clk);
        check("fatal", {dg, ten, t_o}, {DIAG_FATAL, 2'h0});
        line_b = 1'h1;
        host(1'h0, CMD_APPLY, 8'h00);
        check("locked", {seen_o, dg}, {6'h00, DIAG_FATAL});
        resetn = 1'h0;
        repeat (20) @(negedge clk);
        resetn = 1'h1;
        repeat (2) @(negedge clk);
        check("cold", dg, DIAG_MOTOR_OFF);
        host(1'h1, CMD_APPLY, 8'h00);
        check("restart", ten, 1'h1);
        img.profile_selection = PROFILE_MOTOR_OFF;
        host(1'h1, CMD_APPLY, 8'h00);
        check("motor off", {ten, dg}, {1'h0, DIAG_MOTOR_OFF});
    endtask : t_torque
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'h1;
        repeat (2) @(negedge clk);
        t_reset();
        t_apply();
        t_motion();
        t_invalid();
        t_recipe();
        t_torque();
        tally_and_finish();
    end
endmodule : gripper_process_data_handshake_tb_top
`default_nettype wire
